//--- hdl/timer16_compare_defines.vh
`ifndef TIMER16_COMPARE_DEFINES_VH
`define TIMER16_COMPARE_DEFINES_VH
// byte-wide register indices; bus byte address is four times the index
`define CMP_A_LO_IDX      8'h98
`define CMP_A_HI_IDX      8'h99
`define CMP_B_LO_IDX      8'h9a
`define CMP_B_HI_IDX      8'h9b
`define CTRL_A_IDX        8'ha0
`define CTRL_B_IDX        8'ha1
`define IRQ_STATUS_IDX    8'ha8
`define IRQ_MASK_IDX      8'ha9
`define PIN_CTRL_IDX      8'haa
`define TIMER_STATUS_IDX  8'hab
`define CMP_RESET         16'h0000
`define CTRL_RESET        8'h00
// timer_control_a fields
`define ACT_A_HI          7
`define ACT_A_LO          6
`define ACT_B_HI          5
`define ACT_B_LO          4
`define MODE_LO_HI        1
`define MODE_LO_LO        0
// control register b holds the upper mode bits at 4:3
`define MODE_UP_HI        4
`define MODE_UP_LO        3
// waveform modes
`define MODE_PC8          4'h1
`define MODE_PC9          4'h2
`define MODE_PC10         4'h3
`define MODE_FP8          4'h5
`define MODE_FP9          4'h6
`define MODE_FP10         4'h7
`define MODE_PFC_ICR      4'h8
`define MODE_PFC_CMPA     4'h9
`define MODE_PC_ICR       4'ha
`define MODE_PC_CMPA      4'hb
`define MODE_RESERVED     4'hd
`define MODE_FP_ICR       4'he
`define MODE_FP_CMPA      4'hf
`define TOP_8BIT          16'h00ff
`define TOP_9BIT          16'h01ff
`define TOP_10BIT         16'h03ff
`define TOP_MAX           16'hffff
`endif

//--- hdl/timer16_compare_output_unit.v
`timescale 1ns/100ps
`include "timer16_compare_defines.vh"

module timer16_compare_output_unit (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        timer_tick,
  input  wire [15:0] counter_value,
  input  wire        count_down,
  input  wire [15:0] capture_top,
  input  wire        counter_written,
  input  wire        port_d_bit2,
  input  wire        port_out_a,
  input  wire        port_out_b,
  output wire        pin_a_out,
  output wire        pin_a_oe,
  output wire        pin_b_out,
  output wire        pin_b_oe,
  output wire        match_a,
  output wire        match_b,
  output wire [3:0]  waveform_mode,
  output wire        irq
);

  reg  [15:0] cmp_a_q;
  reg  [15:0] cmp_b_q;
  reg  [7:0]  hi_latch_q;
  reg  [7:0]  ctrl_a_q;
  reg  [7:0]  ctrl_b_q;
  reg  [1:0]  irq_stat_q;
  reg  [1:0]  irq_mask_q;
  reg  [1:0]  pin_dir_q;
  reg         modulator_q;
  reg         wave_a_q;
  reg         wave_b_q;
  reg         wave_a_d;
  reg         wave_b_d;

  wire        wr_en;
  wire        rd_en;
  wire [9:0]  idx;
  wire        mapped;
  wire [1:0]  act_a;
  wire [1:0]  act_b;
  reg  [15:0] top_val;
  reg         is_fast;
  reg         is_phase;

  // zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign idx     = paddr[11:2];
  // one select per byte register; the bus byte address is four times the index
  wire        sel_cmp_a_lo;
  wire        sel_cmp_a_hi;
  wire        sel_cmp_b_lo;
  wire        sel_cmp_b_hi;
  wire        sel_ctrl_a;
  wire        sel_ctrl_b;
  wire        sel_irq_stat;
  wire        sel_irq_mask;
  wire        sel_pin_ctrl;
  wire        sel_tstat;
  assign sel_cmp_a_lo = (idx == {2'b00, `CMP_A_LO_IDX});
  assign sel_cmp_a_hi = (idx == {2'b00, `CMP_A_HI_IDX});
  assign sel_cmp_b_lo = (idx == {2'b00, `CMP_B_LO_IDX});
  assign sel_cmp_b_hi = (idx == {2'b00, `CMP_B_HI_IDX});
  assign sel_ctrl_a   = (idx == {2'b00, `CTRL_A_IDX});
  assign sel_ctrl_b   = (idx == {2'b00, `CTRL_B_IDX});
  assign sel_irq_stat = (idx == {2'b00, `IRQ_STATUS_IDX});
  assign sel_irq_mask = (idx == {2'b00, `IRQ_MASK_IDX});
  assign sel_pin_ctrl = (idx == {2'b00, `PIN_CTRL_IDX});
  assign sel_tstat    = (idx == {2'b00, `TIMER_STATUS_IDX});
  assign mapped  = sel_cmp_a_lo | sel_cmp_a_hi | sel_cmp_b_lo | sel_cmp_b_hi | sel_ctrl_a | sel_ctrl_b |
                   sel_irq_stat | sel_irq_mask | sel_pin_ctrl | sel_tstat;

  // write strobes; both high-byte indices feed the one shared latch
  wire        we_hi_latch;
  wire        we_cmp_a;
  wire        we_cmp_b;
  wire        we_ctrl_a;
  wire        we_ctrl_b;
  wire        we_irq_clr;
  wire        we_irq_mask;
  wire        we_pin_ctrl;
  assign we_hi_latch = wr_en & (sel_cmp_a_hi | sel_cmp_b_hi);
  assign we_cmp_a    = wr_en & sel_cmp_a_lo;
  assign we_cmp_b    = wr_en & sel_cmp_b_lo;
  assign we_ctrl_a   = wr_en & sel_ctrl_a;
  assign we_ctrl_b   = wr_en & sel_ctrl_b;
  assign we_irq_clr  = wr_en & sel_irq_stat;
  assign we_irq_mask = wr_en & sel_irq_mask;
  assign we_pin_ctrl = wr_en & sel_pin_ctrl;
  assign pslverr = psel & penable & ~mapped;

  assign act_a         = ctrl_a_q[`ACT_A_HI:`ACT_A_LO];
  assign act_b         = ctrl_a_q[`ACT_B_HI:`ACT_B_LO];
  assign waveform_mode = {ctrl_b_q[`MODE_UP_HI:`MODE_UP_LO], ctrl_a_q[`MODE_LO_HI:`MODE_LO_LO]};

  // a counter write blocks the compare on that tick
  assign match_a = timer_tick & ~counter_written & (counter_value == cmp_a_q);
  assign match_b = timer_tick & ~counter_written & (counter_value == cmp_b_q);

  // mode decode: group and top source
  always @* begin
    is_fast  = 1'b0;
    is_phase = 1'b0;
    top_val  = `TOP_MAX;
    case (waveform_mode)
      `MODE_PC8: begin
        is_phase = 1'b1;
        top_val  = `TOP_8BIT;
      end
      `MODE_PC9: begin
        is_phase = 1'b1;
        top_val  = `TOP_9BIT;
      end
      `MODE_PC10: begin
        is_phase = 1'b1;
        top_val  = `TOP_10BIT;
      end
      `MODE_FP8: begin
        is_fast = 1'b1;
        top_val = `TOP_8BIT;
      end
      `MODE_FP9: begin
        is_fast = 1'b1;
        top_val = `TOP_9BIT;
      end
      `MODE_FP10: begin
        is_fast = 1'b1;
        top_val = `TOP_10BIT;
      end
      `MODE_PFC_ICR, `MODE_PC_ICR: begin
        is_phase = 1'b1;
        top_val  = capture_top;
      end
      `MODE_PFC_CMPA, `MODE_PC_CMPA: begin
        is_phase = 1'b1;
        top_val  = cmp_a_q;
      end
      `MODE_FP_ICR: begin
        is_fast = 1'b1;
        top_val = capture_top;
      end
      `MODE_FP_CMPA: begin
        is_fast = 1'b1;
        top_val = cmp_a_q;
      end
      // reserved mode 13 behaves as non-pwm, keeping outputs predictable
      default: begin
        is_fast  = 1'b0;
        is_phase = 1'b0;
      end
    endcase
  end

  // bottom is seen on a tick only; a counter write masks it like a match
  wire        pwm_grp;
  wire        bottom_ev;
  wire        toggle_ok;
  wire        top_hit_a;
  wire        top_hit_b;
  assign pwm_grp   = is_fast | is_phase;
  assign bottom_ev = timer_tick & ~counter_written & (counter_value == 16'h0000);
  // channel a may toggle in a pwm group only in four modes
  assign toggle_ok = (is_fast & ((waveform_mode == `MODE_FP_ICR) | (waveform_mode == `MODE_FP_CMPA))) |
                     (is_phase & ((waveform_mode == `MODE_PFC_CMPA) |
                                  (waveform_mode == `MODE_PC_CMPA)));
  // in fast pwm a compare value sitting on top still fires its match but never sets or clears its level
  assign top_hit_a = is_fast & (cmp_a_q == top_val);
  assign top_hit_b = is_fast & (cmp_b_q == top_val);

  // channel a next level; the flop holds unless a match or bottom acts on it
  always @* begin
    wave_a_d = wave_a_q;
    if (!pwm_grp) begin
      if (match_a) begin
        case (act_a)
          2'h1:    wave_a_d = ~wave_a_q;
          2'h2:    wave_a_d = 1'b0;
          2'h3:    wave_a_d = 1'b1;
          default: wave_a_d = wave_a_q;
        endcase
      end
    end else if (is_fast) begin
      if (act_a == 2'h1 && toggle_ok && match_a)
        wave_a_d = ~wave_a_q;
      // bottom wins over a match on the same tick
      if (act_a[1]) begin
        if (bottom_ev)
          wave_a_d = ~act_a[0];
        else if (match_a && !top_hit_a)
          wave_a_d = act_a[0];
      end
    end else begin
      if (act_a == 2'h1 && toggle_ok && match_a)
        wave_a_d = ~wave_a_q;
      if (act_a[1] && match_a)
        wave_a_d = act_a[0] ^ count_down;
    end
  end

  // channel b never toggles in a pwm group
  always @* begin
    wave_b_d = wave_b_q;
    if (!pwm_grp) begin
      if (match_b) begin
        case (act_b)
          2'h1:    wave_b_d = ~wave_b_q;
          2'h2:    wave_b_d = 1'b0;
          2'h3:    wave_b_d = 1'b1;
          default: wave_b_d = wave_b_q;
        endcase
      end
    end else if (is_fast) begin
      if (act_b[1]) begin
        if (bottom_ev)
          wave_b_d = ~act_b[0];
        else if (match_b && !top_hit_b)
          wave_b_d = act_b[0];
      end
    end else begin
      if (act_b[1] && match_b)
        wave_b_d = act_b[0] ^ count_down;
    end
  end

  // each waveform level is its own flop; a pin follows one cycle after its event
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wave_a_q <= 1'b0;
    end else begin
      wave_a_q <= wave_a_d;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wave_b_q <= 1'b0;
    end else begin
      wave_b_q <= wave_b_d;
    end
  end

  // a toggle setting in a pwm group leaves the pin to the port, except channel a in its modes
  wire        tog_off_a;
  wire        tog_off_b;
  wire        conn_a;
  wire        conn_b;
  wire        b_gate;
  assign tog_off_a = pwm_grp & (act_a == 2'h1) & ~toggle_ok;
  assign tog_off_b = pwm_grp & (act_b == 2'h1);
  assign conn_a    = (|act_a) & ~tog_off_a;
  assign conn_b    = (|act_b) & ~tog_off_b;
  // without the modulator the b pin also needs the port bit
  assign b_gate    = modulator_q | port_d_bit2;

  assign pin_a_out = conn_a ? wave_a_q : port_out_a;
  assign pin_b_out = (conn_b & b_gate) ? wave_b_q : port_out_b;
  assign pin_a_oe  = pin_dir_q[0];
  assign pin_b_oe  = pin_dir_q[1];
  // interrupt is a level: high while any unmasked flag stands
  wire [1:0]  irq_pend;
  assign irq_pend  = irq_stat_q & irq_mask_q;
  assign irq       = |irq_pend;

  // compare values and the shared latch; the high byte only reaches the latch
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_a_q    <= `CMP_RESET;
      cmp_b_q    <= `CMP_RESET;
      hi_latch_q <= 8'h00;
    end else begin
      if (we_hi_latch)
        hi_latch_q <= pwdata[7:0];
      // a low-byte write alone commits whatever the latch last held
      if (we_cmp_a)
        cmp_a_q <= {hi_latch_q, pwdata[7:0]};
      if (we_cmp_b)
        cmp_b_q <= {hi_latch_q, pwdata[7:0]};
    end
  end

  // control registers; unused bits 3:2 of control a stay zero
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_a_q <= `CTRL_RESET;
      ctrl_b_q <= `CTRL_RESET;
    end else begin
      if (we_ctrl_a)
        ctrl_a_q <= pwdata[7:0] & 8'hf3;
      if (we_ctrl_b)
        ctrl_b_q <= pwdata[7:0];
    end
  end

  // interrupt flags: set wins over a simultaneous write-one clear
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_q <= 2'h0;
      irq_mask_q <= 2'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(we_irq_clr ? pwdata[1:0] : 2'h0)) | {match_b, match_a};
      if (we_irq_mask)
        irq_mask_q <= pwdata[1:0];
    end
  end

  // pin control: direction bits and modulator-in-use flag
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pin_dir_q   <= 2'h0;
      modulator_q <= 1'b0;
    end else if (we_pin_ctrl) begin
      pin_dir_q   <= pwdata[1:0];
      modulator_q <= pwdata[2];
    end
  end

  // status byte: live wave levels, fast group and count direction
  wire [7:0]  tstat_byte;
  assign tstat_byte = {4'h0, count_down, is_fast, wave_b_q, wave_a_q};

  // read data; high byte reads the live register half
  always @* begin
    prdata = 32'h00000000;
    if (rd_en) begin
      case (idx)
        {2'b00, `CMP_A_LO_IDX}:     prdata = {24'h000000, cmp_a_q[7:0]};
        {2'b00, `CMP_A_HI_IDX}:     prdata = {24'h000000, cmp_a_q[15:8]};
        {2'b00, `CMP_B_LO_IDX}:     prdata = {24'h000000, cmp_b_q[7:0]};
        {2'b00, `CMP_B_HI_IDX}:     prdata = {24'h000000, cmp_b_q[15:8]};
        {2'b00, `CTRL_A_IDX}:       prdata = {24'h000000, ctrl_a_q};
        {2'b00, `CTRL_B_IDX}:       prdata = {24'h000000, ctrl_b_q};
        {2'b00, `IRQ_STATUS_IDX}:   prdata = {30'h00000000, irq_stat_q};
        {2'b00, `IRQ_MASK_IDX}:     prdata = {30'h00000000, irq_mask_q};
        {2'b00, `PIN_CTRL_IDX}:     prdata = {29'h00000000, modulator_q, pin_dir_q};
        {2'b00, `TIMER_STATUS_IDX}: prdata = {24'h000000, tstat_byte};
        default:                    prdata = 32'h00000000;
      endcase
    end
  end

endmodule

//--- sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        clock, sys_rst, psel, penable, pwrite, timer_tick, count_down, counter_written, e;
  logic        port_d_bit2, port_out_a, port_out_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] counter_value, capture_top;
  wire         pready, pslverr, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, match_a, match_b, irq;
  wire  [3:0]  waveform_mode;
  int          err_total, checks, cyc;
  logic [23:0] tbl [0:23];
  timer16_compare_output_unit u_timer16_compare_output_unit (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_tick(timer_tick), .counter_value(counter_value), .count_down(count_down),
    .capture_top(capture_top), .counter_written(counter_written), .port_d_bit2(port_d_bit2),
    .port_out_a(port_out_a), .port_out_b(port_out_b), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
    .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .match_a(match_a), .match_b(match_b),
    .waveform_mode(waveform_mode), .irq(irq));
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input [31:0] seen, input [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  task automatic bus(input wr, input [7:0] idx, input [7:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input [7:0] idx, input [7:0] exp, input string msg);
    bus(1'b0, idx, 8'h00);
    check(rd, {24'h0, exp}, msg);
  endtask
  // table: ctrl a, ctrl b, {cnt_wr, match, down, port, pin a, pin b}
  task automatic step(input int i);
    logic [23:0] s;
    s = tbl[i];
    bus(1'b1, 8'ha0, s[23:16]);
    bus(1'b1, 8'ha1, s[15:8]);
    @(posedge clock);
    counter_value <= s[4] ? 16'h0010 : 16'h0000;
    count_down <= s[3];
    port_out_a <= s[2];
    port_out_b <= s[2];
    counter_written <= s[5];
    port_d_bit2 <= (i != 21);
    timer_tick <= 1'b1;
    #1;
    check(match_a, s[4] & ~s[5], "match strobe");
    check(match_b, s[4] & ~s[5], "match strobe b");
    @(posedge clock);
    timer_tick <= 1'b0;
    counter_written <= 1'b0;
    counter_value <= 16'h0005;
    repeat (2) @(posedge clock);
    #1;
    check(pin_a_out, s[1], "pin a level");
    check(pin_b_out, s[0], "pin b level");
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, timer_tick, counter_value} = '0;
    {count_down, counter_written, port_out_a, port_out_b} = '0;
    capture_top = 16'h0010;
    {err_total, checks, cyc} = '0;
    sys_rst = 1'b1;
    port_d_bit2 = 1'b1;
    tbl = '{24'hf00013, 24'ha00010, 24'h500013, 24'h500010, 24'h000017, 24'ha10803, 24'ha10810,
            24'hf10800, 24'hf10813, 24'h510810, 24'he31801, 24'h531812, 24'ha31803, 24'ha31813,
            24'ha10014, 24'ha1001b, 24'hf1001c, 24'hf10013, 24'h531015, 24'h511012, 24'ha11814,
            24'hf00012, 24'ha00033, 24'h521815};
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    check({irq, pin_a_oe}, 2'b00, "outputs after reset");
    for (int k = 0; k < 5; k++) rchk(k < 4 ? 8'h98 + k : 8'ha0, 8'h00, "reset value");
    bus(1'b1, 8'h99, 8'h12);
    bus(1'b1, 8'h98, 8'h34);
    bus(1'b1, 8'h9a, 8'h56);
    rchk(8'h98, 8'h34, "low byte");
    rchk(8'h9b, 8'h12, "shared latch");
    bus(1'b1, 8'ha0, 8'hff);
    rchk(8'ha0, 8'hf3, "ctrl a fields");
    bus(1'b1, 8'ha1, 8'h18);
    #1;
    check(waveform_mode, 4'hf, "mode combine");
    bus(1'b0, 8'h00, 8'h00);
    check(e, 1'b1, "unmapped error");
    check(rd, 32'h0, "unmapped read");
    check(pready, 1'b1, "zero wait");
    bus(1'b1, 8'haa, 8'h01);
    #1;
    check({pin_b_oe, pin_a_oe}, 2'b01, "dir bits");
    bus(1'b1, 8'haa, 8'h03);
    bus(1'b1, 8'h99, 8'h00);
    bus(1'b1, 8'h98, 8'h10);
    bus(1'b1, 8'h9a, 8'h10);
    for (int i = 0; i < 24; i++) step(i);
    rchk(8'hab, 8'h06, "status byte");
    rchk(8'ha8, 8'h03, "irq status");
    check(irq, 1'b0, "masked irq");
    bus(1'b1, 8'ha9, 8'h01);
    #1;
    check(irq, 1'b1, "irq raised");
    bus(1'b1, 8'ha8, 8'h01);
    #1;
    check(irq, 1'b0, "irq cleared");
    rchk(8'ha8, 8'h02, "one clear");
    tally_and_finish();
  end
endmodule

//--- sim/timer16_compare_checker_props.sv
`timescale 1ns/100ps
module timer16_compare_checker (
  input logic        clock,
  input logic        sys_rst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        timer_tick,
  input logic        counter_written,
  input logic        port_out_a,
  input logic        pin_a_out,
  input logic        pin_a_oe,
  input logic        match_a,
  input logic        match_b,
  input logic [3:0]  waveform_mode,
  input logic        irq
);
  wire wr = psel && penable && pwrite;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_ready_zero_wait: assert property (s_setup ##1 s_access |-> pready) else $error("no ready in access");
  a_match_a_tick: assert property (match_a |-> timer_tick && !counter_written) else $error("stray match a");
  a_match_b_tick: assert property (match_b |-> timer_tick && !counter_written) else $error("stray match b");
  a_slverr_access: assert property (pslverr |-> psel && penable) else $error("error outside access");
  a_rdata_idle: assert property (!psel |-> prdata == 32'h0) else $error("read data while idle");
  a_mode_by_write: assert property ($changed(waveform_mode) |-> $past(wr)) else $error("mode moved alone");
  a_oe_by_write: assert property ($changed(pin_a_oe) |-> $past(wr)) else $error("enable moved alone");
  a_pin_cause: assert property ($changed(pin_a_out) |-> $changed(port_out_a) || $past(timer_tick)
    || $past(timer_tick, 2) || $past(wr) || $past(wr, 2)) else $error("pin moved without cause");
  a_irq_cause: assert property ($changed(irq) |-> $past(match_a || match_b) || $past(wr))
    else $error("irq moved without cause");
endmodule
bind timer16_compare_output_unit timer16_compare_checker u_chk (.*);
